// ==== hw/pin_input_route_and_analog_select.sv ====
// Pin analog select, function priority, pulls and interrupt input routing
// Overview of operation
// RULE1 - After reset every analog-capable pin starts in analog mode.
// RULE2 - Analog pins read zero through pin level and latch registers.
// RULE3 - Software writes one to an analog select bit for digital use.
// RULE4 - Output driver follows direction bit even while analog is active.
// RULE5 - Leftmost enabled function owns a pin; all to its right are off.
// RULE6 - Each pin has independent pull-up and pull-down enable bits.
// RULE7 - Bits 14 to 8 of the first route register pick irq one source.
// RULE8 - Bits 6 to 0 of the second route register pick irq two source.
// RULE9 - Code zero is ground, one comparator, codes 2 to 121 remappable pins.
// RULE10 - Unimplemented route register bits ignore writes and read zero.
// RULE11 - Both selectors clear at reset, so both interrupts see ground.
// RULE12 - No interlock between selectors; any combination is accepted.
// RULE13 - Selector change reaches the interrupt output the cycle after.
`timescale 1ns/1ns
module pin_input_route_and_analog_select
  import pin_route_pkg::*;
#(
  parameter int PIN_W = 16,
  parameter int NUM_FUNC = 4,
  parameter logic [PIN_W-1:0] ANALOG_MASK = 16'hFFFF
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Avalon-MM slave
  input wire avmm_req_s avmm_i,
  output logic [DATA_W-1:0] avmm_readdata_o,
  output logic avmm_waitrequest_o,
  // Pads
  input wire logic [PIN_W-1:0] pin_in_i,
  output logic [PIN_W-1:0] pin_out_o,
  output logic [PIN_W-1:0] pin_oe_o,
  output logic [PIN_W-1:0] pullup_enable_o,
  output logic [PIN_W-1:0] pulldown_enable_o,
  // Function arbitration
  input wire logic [(NUM_FUNC-1)*PIN_W-1:0] func_req_i,
  output logic [NUM_FUNC*PIN_W-1:0] func_grant_o,
  output logic [PIN_W-1:0] digital_in_o,
  // Interrupt input routing
  input wire logic comparator_one_output_i,
  input wire logic [REMAP_W-1:0] remappable_pin_i,
  output logic external_irq_one_o,
  output logic external_irq_two_o
);

  // Lowest set bit, index zero being leftmost in the pin name
  function automatic logic [NUM_FUNC-1:0] first_set(
    input logic [NUM_FUNC-1:0] v);
    first_set = v & (~v + {{(NUM_FUNC-1){1'b0}}, 1'b1});
  endfunction

  // Source multiplexer for a routed input
  function automatic logic route_src(input logic [SEL_W-1:0] sel,
                                     input logic cmp,
                                     input logic [REMAP_W-1:0] rp);
    if (sel == SEL_CODE_GND) begin
      route_src = 1'b0;
    end else if (sel == SEL_CODE_CMP) begin
      route_src = cmp;
    end else if (sel > SEL_CODE_MAX) begin
      route_src = 1'b0;
    end else begin
      route_src = rp[sel];
    end
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [BE_W-1:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[LANE_W-1:0] = wd[LANE_W-1:0];
    end
    if (be[1]) begin
      merge16[REG_W-1:LANE_W] = wd[REG_W-1:LANE_W];
    end
  endfunction

  bus_state_e state_reg;
  bus_state_e state_next;
  logic [REG_W-1:0] analog_sel_reg;
  logic [REG_W-1:0] dir_reg;
  logic [REG_W-1:0] latch_reg;
  logic [REG_W-1:0] pullup_reg;
  logic [REG_W-1:0] pulldown_reg;
  logic [SEL_W-1:0] irq1_source_select_reg;
  logic [SEL_W-1:0] irq2_source_select_reg;

  wire req = avmm_i.read | avmm_i.write;
  wire wr_take = (state_reg == BUS_ACK) & avmm_i.write;
  wire [ADDR_W-1:0] addr = avmm_i.address;
  wire [BE_W-1:0] be = avmm_i.byteenable;
  wire [DATA_W-1:0] wd = avmm_i.writedata;

  // Digital buffer enable: analog select bit one means digital
  wire [PIN_W-1:0] digital_en = analog_sel_reg[PIN_W-1:0] | ~ANALOG_MASK;
  wire [PIN_W-1:0] analog_active = ~digital_en;
  // Analog pins read zero
  wire [PIN_W-1:0] pin_level_value = pin_in_i & digital_en;
  wire [PIN_W-1:0] output_latch_value = latch_reg[PIN_W-1:0] & digital_en;

  // Route register images, unused bits zero
  wire [REG_W-1:0] irq1_route_img =
    {1'b0, irq1_source_select_reg, {LANE_W{1'b0}}};
  wire [REG_W-1:0] irq2_route_img =
    {{(REG_W-SEL_W){1'b0}}, irq2_source_select_reg};
  wire [REG_W-1:0] irq1_merged = merge16(irq1_route_img, wd, be);
  wire [REG_W-1:0] irq2_merged = merge16(irq2_route_img, wd, be);

  // Interrupt source multiplexers
  wire irq1_src = route_src(irq1_source_select_reg,
                            comparator_one_output_i, remappable_pin_i);
  wire irq2_src = route_src(irq2_source_select_reg,
                            comparator_one_output_i, remappable_pin_i);

  // Read data decode
  logic [REG_W-1:0] rd_word;
  always_comb begin
    rd_word = {REG_W{1'b0}};
    if (addr == OFF_ANALOG_SEL) begin
      rd_word = analog_sel_reg;
    end else if (addr == OFF_DIRECTION) begin
      rd_word = dir_reg;
    end else if (addr == OFF_LATCH) begin
      rd_word = {{(REG_W-PIN_W){1'b0}}, output_latch_value};
    end else if (addr == OFF_PIN_LEVEL) begin
      rd_word = {{(REG_W-PIN_W){1'b0}}, pin_level_value};
    end else if (addr == OFF_PULLUP) begin
      rd_word = pullup_reg;
    end else if (addr == OFF_PULLDOWN) begin
      rd_word = pulldown_reg;
    end else if (addr == OFF_IRQ1_ROUTE) begin
      rd_word = irq1_route_img;
    end else if (addr == OFF_IRQ2_ROUTE) begin
      rd_word = irq2_route_img;
    end
  end

  // Handshake: waitrequest drops for one cycle per request
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BUS_IDLE: begin
        if (req) begin
          state_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        state_next = BUS_IDLE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_reg <= BUS_IDLE;
      avmm_waitrequest_o <= 1'b1;
      avmm_readdata_o <= RDATA_RST;
    end else begin
      state_reg <= state_next;
      avmm_waitrequest_o <= (state_next != BUS_ACK);
      if (state_reg == BUS_IDLE && avmm_i.read) begin
        avmm_readdata_o <= {{(DATA_W-REG_W){1'b0}}, rd_word};
      end
    end
  end

  // Analog mode at reset, digital when software sets the bit
  // RULE1 RULE3 analog select
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      analog_sel_reg <= ANALOG_SEL_RST;
    end else if (wr_take && addr == OFF_ANALOG_SEL) begin
      analog_sel_reg <= merge16(analog_sel_reg, wd, be);
    end
  end

  // Port direction, latch and pull enables
  // RULE6 independent pulls
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dir_reg <= DIRECTION_RST;
      latch_reg <= LATCH_RST;
      pullup_reg <= PULL_RST;
      pulldown_reg <= PULL_RST;
    end else if (wr_take) begin
      if (addr == OFF_DIRECTION) begin
        dir_reg <= merge16(dir_reg, wd, be);
      end
      if (addr == OFF_LATCH) begin
        latch_reg <= merge16(latch_reg, wd, be);
      end
      if (addr == OFF_PULLUP) begin
        pullup_reg <= merge16(pullup_reg, wd, be);
      end
      if (addr == OFF_PULLDOWN) begin
        pulldown_reg <= merge16(pulldown_reg, wd, be);
      end
    end
  end

  // Selectors, cleared at reset, written without interlock
  // RULE7 RULE8 RULE10 RULE11 RULE12 selectors
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq1_source_select_reg <= SEL_RST;
      irq2_source_select_reg <= SEL_RST;
    end else if (wr_take) begin
      if (addr == OFF_IRQ1_ROUTE) begin
        irq1_source_select_reg <= irq1_merged[IRQ1_SEL_MSB:IRQ1_SEL_LSB];
      end
      if (addr == OFF_IRQ2_ROUTE) begin
        irq2_source_select_reg <= irq2_merged[IRQ2_SEL_MSB:IRQ2_SEL_LSB];
      end
    end
  end

  // Pad and interrupt outputs
  // RULE4 RULE9 RULE13 output stage
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pin_out_o <= {PIN_W{1'b0}};
      pin_oe_o <= {PIN_W{1'b0}};
      pullup_enable_o <= {PIN_W{1'b0}};
      pulldown_enable_o <= {PIN_W{1'b0}};
      digital_in_o <= {PIN_W{1'b0}};
      external_irq_one_o <= 1'b0;
      external_irq_two_o <= 1'b0;
    end else begin
      pin_out_o <= latch_reg[PIN_W-1:0];
      pin_oe_o <= ~dir_reg[PIN_W-1:0];
      pullup_enable_o <= pullup_reg[PIN_W-1:0];
      pulldown_enable_o <= pulldown_reg[PIN_W-1:0];
      digital_in_o <= pin_level_value;
      external_irq_one_o <= irq1_src;
      external_irq_two_o <= irq2_src;
    end
  end

  // Per-pin function arbitration, analog first
  genvar p;
  generate
    for (p = 0; p < PIN_W; p++) begin : g_pin
      wire [NUM_FUNC-1:0] f_req =
        {func_req_i[p*(NUM_FUNC-1) +: (NUM_FUNC-1)], analog_active[p]};
      // RULE5 leftmost wins
      wire [NUM_FUNC-1:0] f_grant = first_set(f_req);
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          func_grant_o[p*NUM_FUNC +: NUM_FUNC] <= {NUM_FUNC{1'b0}};
        end else begin
          func_grant_o[p*NUM_FUNC +: NUM_FUNC] <= f_grant;
        end
      end
    end
  endgenerate

  property p_analog_after_reset;
    @(posedge mclk_i) disable iff (srst_i)
    $fell(srst_i) |-> (analog_sel_reg == ANALOG_SEL_RST) && (digital_in_o
      == {PIN_W{1'b0}}) ##1 (digital_in_o & ANALOG_MASK) == {PIN_W{1'b0}};
  endproperty
  a_analog_after_reset: assert property (p_analog_after_reset) // RULE1
    else $error("pin not analog after reset");

  property p_analog_reads_zero;
    @(posedge mclk_i) disable iff (srst_i)
    (state_reg == BUS_IDLE && avmm_i.read && addr == OFF_PIN_LEVEL) |=>
      ((avmm_readdata_o[PIN_W-1:0] & ~$past(digital_en)) == {PIN_W{1'b0}});
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero) // RULE2
    else $error("analog pin read nonzero");

  property p_oe_with_analog;
    @(posedge mclk_i) disable iff (srst_i)
    (analog_active[0] && !dir_reg[0]) |=> pin_oe_o[0];
  endproperty
  a_oe_with_analog: assert property (p_oe_with_analog) // RULE4
    else $error("output driver lost while analog");

  // Pin zero requests, analog in bit zero
  wire [NUM_FUNC-1:0] f0_req = g_pin[0].f_req;

  property p_priority;
    @(posedge mclk_i) disable iff (srst_i)
    f0_req[0] |=> func_grant_o[NUM_FUNC-1:0] ==
      {{(NUM_FUNC-1){1'b0}}, 1'b1};
  endproperty
  a_priority: assert property (p_priority) // RULE5
    else $error("higher priority function not owner");

  property p_grant_onehot;
    @(posedge mclk_i) disable iff (srst_i)
    (f0_req != {NUM_FUNC{1'b0}}) |=>
      $onehot(func_grant_o[NUM_FUNC-1:0]) &&
      ((func_grant_o[NUM_FUNC-1:0] & ~$past(f0_req)) == {NUM_FUNC{1'b0}});
  endproperty
  a_grant_onehot: assert property (p_grant_onehot) // RULE5
    else $error("function grant not single");

  property p_pulls;
    @(posedge mclk_i) disable iff (srst_i)
    !$rose(srst_i) |=> (pullup_enable_o == $past(pullup_reg[PIN_W-1:0])) &&
      (pulldown_enable_o == $past(pulldown_reg[PIN_W-1:0]));
  endproperty
  a_pulls: assert property (p_pulls) // RULE6
    else $error("pull enables wrong");

  property p_irq1_write;
    @(posedge mclk_i) disable iff (srst_i)
    (wr_take && addr == OFF_IRQ1_ROUTE && be[1]) |=>
      irq1_source_select_reg == $past(wd[IRQ1_SEL_MSB:IRQ1_SEL_LSB]);
  endproperty
  a_irq1_write: assert property (p_irq1_write) // RULE7
    else $error("irq one selector not written");

  property p_irq2_write;
    @(posedge mclk_i) disable iff (srst_i)
    (wr_take && addr == OFF_IRQ2_ROUTE && be[0]) |=>
      irq2_source_select_reg == $past(wd[IRQ2_SEL_MSB:IRQ2_SEL_LSB]);
  endproperty
  a_irq2_write: assert property (p_irq2_write) // RULE8
    else $error("irq two selector not written");

  property p_code_map;
    @(posedge mclk_i) disable iff (srst_i)
    (irq1_source_select_reg == SEL_CODE_GND |=> !external_irq_one_o) and
    (irq1_source_select_reg == SEL_CODE_CMP |=>
      external_irq_one_o == $past(comparator_one_output_i)) and
    (irq2_source_select_reg == SEL_CODE_MAX |=>
      external_irq_two_o == $past(remappable_pin_i[REMAP_W-1]));
  endproperty
  a_code_map: assert property (p_code_map) // RULE9 RULE13
    else $error("selector code routes wrong source");

  property p_unused_zero;
    @(posedge mclk_i) disable iff (srst_i)
    (state_reg == BUS_IDLE && avmm_i.read && addr == OFF_IRQ1_ROUTE) |=>
      avmm_readdata_o[LANE_W-1:0] == 8'h00 &&
      avmm_readdata_o[DATA_W-1:IRQ1_SEL_MSB+1] == {(DATA_W-15){1'b0}};
  endproperty
  a_unused_zero: assert property (p_unused_zero) // RULE10
    else $error("unimplemented route bits not zero");

  property p_sel_reset;
    @(posedge mclk_i) disable iff (srst_i)
    $fell(srst_i) |-> irq1_source_select_reg == SEL_RST &&
      irq2_source_select_reg == SEL_RST ##1 !external_irq_one_o;
  endproperty
  a_sel_reset: assert property (p_sel_reset) // RULE11
    else $error("selectors not cleared by reset");

endmodule // pin_input_route_and_analog_select

// ==== hw/pin_route_pkg.sv ====
// Constants, register map and carrier types for the pin routing block
package pin_route_pkg;

  // Widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int BE_W = 4;
  localparam int REG_W = 16;
  localparam int SEL_W = 7;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ANALOG_SEL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DIRECTION = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LATCH = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PIN_LEVEL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PULLUP = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PULLDOWN = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ1_ROUTE = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ2_ROUTE = 8'h1C;

  // Selector field positions
  localparam int IRQ1_SEL_LSB = 8;
  localparam int IRQ1_SEL_MSB = 14;
  localparam int IRQ2_SEL_LSB = 0;
  localparam int IRQ2_SEL_MSB = 6;
  localparam int LANE_W = 8;

  // Selector codes
  localparam logic [SEL_W-1:0] SEL_CODE_GND = 7'h00;
  localparam logic [SEL_W-1:0] SEL_CODE_CMP = 7'h01;
  localparam logic [SEL_W-1:0] SEL_CODE_MAX = 7'h79;
  localparam int REMAP_W = 122;

  // Reset values
  localparam logic [REG_W-1:0] ANALOG_SEL_RST = 16'h0000;
  localparam logic [REG_W-1:0] DIRECTION_RST = 16'hFFFF;
  localparam logic [REG_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [REG_W-1:0] PULL_RST = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RST = 7'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } avmm_req_s;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_e;

endpackage

// ==== sim/tb.sv ====
// Self-checking bench for the pin routing block
`timescale 1ns/1ns
module tb
  import pin_route_pkg::*;
();
  logic mclk_i = 1'b0;
  logic srst_i;
  avmm_req_s req;
  logic [DATA_W-1:0] rdata;
  logic wreq;
  logic [15:0] pin_in, pin_out, pin_oe, pu, pd, din;
  logic [47:0] func_req;
  logic [63:0] grant;
  logic cmp, irq1, irq2;
  logic [REMAP_W-1:0] rp;
  int num_errors = 0;
  int num_checks = 0;
  int codes[6] = '{0, 1, 2, 61, 121, 127};
  int c1, c2;

  always #50 mclk_i = ~mclk_i;

  pin_input_route_and_analog_select dut (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .avmm_i(req),
    .avmm_readdata_o(rdata),
    .avmm_waitrequest_o(wreq),
    .pin_in_i(pin_in),
    .pin_out_o(pin_out),
    .pin_oe_o(pin_oe),
    .pullup_enable_o(pu),
    .pulldown_enable_o(pd),
    .func_req_i(func_req),
    .func_grant_o(grant),
    .digital_in_o(din),
    .comparator_one_output_i(cmp),
    .remappable_pin_i(rp),
    .external_irq_one_o(irq1),
    .external_irq_two_o(irq2)
  );

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic rw, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge mclk_i);
    req <= '{read: !rw, write: rw, address: a, writedata: d,
             byteenable: be};
    for (n = 0; n < 20; n++) begin
      @(posedge mclk_i);
      if (wreq === 1'b0) break;
    end
    q = rdata;
    req <= '0;
    if (n == 20) begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(nm, {32'h0000_0000, q}, {32'h0000_0000, e});
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // Owner per pin from analog select and requests
  function automatic logic [63:0] gexp(logic [15:0] a, logic [47:0] r);
    logic [63:0] g;
    g = '0;
    for (int p = 0; p < 16; p++) begin
      if (!a[p]) g[p*4+:4] = 4'h1;
      else if (r[p*3]) g[p*4+:4] = 4'h2;
      else if (r[p*3+1]) g[p*4+:4] = 4'h4;
      else if (r[p*3+2]) g[p*4+:4] = 4'h8;
    end
    return g;
  endfunction

  // Routed level for a selector code
  function automatic logic iexp(int c, logic cm, logic [REMAP_W-1:0] r);
    if (c == 0) return 1'b0;
    if (c == 1) return cm;
    if (c <= 121) return r[c];
    return 1'b0;
  endfunction

  initial begin
    req = '0;
    pin_in = '0;
    func_req = '0;
    cmp = 1'b1;
    rp = {61{2'b10}};
    srst_i = 1'b1;
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    tick(2);
    // Reset state
    chk("irq_one", irq1, 0);
    chk("irq_two", irq2, 0);
    rd("analog_sel", OFF_ANALOG_SEL, 32'h0000_0000);
    rd("direction", OFF_DIRECTION, 32'h0000_FFFF);
    rd("pullup", OFF_PULLUP, 32'h0000_0000);
    rd("pulldown", OFF_PULLDOWN, 32'h0000_0000);
    rd("route_one", OFF_IRQ1_ROUTE, 32'h0000_0000);
    rd("route_two", OFF_IRQ2_ROUTE, 32'h0000_0000);
    rd("unmapped", 8'h20, 32'h0000_0000);
    // All pins analog
    @(posedge mclk_i);
    pin_in <= 16'hFFFF;
    func_req <= {16{3'b111}};
    wr(OFF_LATCH, 32'h0000_FFFF, 4'hF);
    wr(OFF_DIRECTION, 32'h0000_0000, 4'hF);
    tick(2);
    chk("digital_in", din, 0);
    chk("grant", grant, gexp(16'h0000, func_req));
    chk("pin_oe", pin_oe, 16'hFFFF);
    chk("pin_out", pin_out, 16'hFFFF);
    rd("pin_level", OFF_PIN_LEVEL, 32'h0000_0000);
    rd("latch", OFF_LATCH, 32'h0000_0000);
    // Low half digital
    wr(OFF_ANALOG_SEL, 32'h0000_00FF, 4'hF);
    @(posedge mclk_i);
    pin_in <= 16'hA5A5;
    for (int p = 0; p < 16; p++) func_req[p*3+:3] <= 3'(p);
    tick(2);
    chk("digital_in", din, 16'h00A5);
    chk("grant", grant, gexp(16'h00FF, func_req));
    rd("pin_level", OFF_PIN_LEVEL, 32'h0000_00A5);
    rd("latch", OFF_LATCH, 32'h0000_00FF);
    rd("analog_sel", OFF_ANALOG_SEL, 32'h0000_00FF);
    // Pull enables
    wr(OFF_PULLUP, 32'h0000_1234, 4'hF);
    wr(OFF_PULLDOWN, 32'h0000_4321, 4'hF);
    tick(2);
    chk("pullup", pu, 16'h1234);
    chk("pulldown", pd, 16'h4321);
    rd("pullup", OFF_PULLUP, 32'h0000_1234);
    rd("pulldown", OFF_PULLDOWN, 32'h0000_4321);
    // Unimplemented route bits
    wr(OFF_IRQ1_ROUTE, 32'hFFFF_FFFF, 4'hF);
    tick(1);
    chk("irq_one", irq1, 0);
    rd("route_one", OFF_IRQ1_ROUTE, 32'h0000_7F00);
    wr(OFF_IRQ1_ROUTE, 32'h0000_0000, 4'h1);
    rd("route_one", OFF_IRQ1_ROUTE, 32'h0000_7F00);
    wr(OFF_IRQ2_ROUTE, 32'hFFFF_FFFF, 4'hF);
    rd("route_two", OFF_IRQ2_ROUTE, 32'h0000_007F);
    // Selector codes
    for (int i = 0; i < 6; i++) begin
      c1 = codes[i];
      c2 = (i == 4) ? c1 : codes[5-i];
      wr(OFF_IRQ1_ROUTE, 32'(c1) << 8, 4'hF);
      wr(OFF_IRQ2_ROUTE, 32'(c2), 4'hF);
      tick(1);
      chk("irq_one", irq1, iexp(c1, cmp, rp));
      chk("irq_two", irq2, iexp(c2, cmp, rp));
      @(posedge mclk_i);
      rp <= ~rp;
      cmp <= ~cmp;
      tick(2);
      chk("irq_one", irq1, iexp(c1, cmp, rp));
      chk("irq_two", irq2, iexp(c2, cmp, rp));
      rd("route_one", OFF_IRQ1_ROUTE, 32'(c1) << 8);
      rd("route_two", OFF_IRQ2_ROUTE, 32'(c2));
    end
    // Mid-run reset with live routing
    wr(OFF_IRQ1_ROUTE, 32'h0000_0100, 4'hF);
    wr(OFF_IRQ2_ROUTE, 32'h0000_0001, 4'hF);
    tick(1);
    chk("irq_one", irq1, cmp);
    chk("irq_two", irq2, cmp);
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    tick(2);
    chk("irq_one", irq1, 0);
    chk("irq_two", irq2, 0);
    chk("digital_in", din, 0);
    rd("analog_sel", OFF_ANALOG_SEL, 32'h0000_0000);
    rd("route_one", OFF_IRQ1_ROUTE, 32'h0000_0000);
    rd("route_two", OFF_IRQ2_ROUTE, 32'h0000_0000);
    close_out();
  end
endmodule // tb
